// File: core/lcs_config_bank.v
// indicator timing and clock synthesizer configuration register bank
//
// Function
// - a nine-bit writable field sets how long the activity indicator stays off.
// - the unit bit picks milliseconds when 0 and microseconds when 1.
// - the selected reference is divided by the three-bit reference divide field.
// - the synthesizer feedback is divided by the three-bit feedback divide field.
// - with bypass set the selected source goes undivided onto the fast clock.
// - the source bit picks the host clock when 0 and the memory clock when 1.
// - the active-low divider reset bit holds the dividers in reset while 0.
// - each synthesizer runs while its power-down bit is 0 and is powered down at 1.
// - each synthesizer is forced into synchronisation mode while its sync bit is 1.
//
// Chosen here: the address-and-strobe port.
`include "lcs_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module lcs_config_bank #(
    parameter AW = 9,
    parameter DW = 16,
    parameter DIV_W = 3,
    parameter TIME_W = 9,
    parameter US_CYC = `LCS_US_CYC,
    parameter MS_US = `LCS_MS_US,
    // arbitrary identification values
    parameter [7:0] PART_CODE = 8'h5A,
    parameter [7:0] REVISION_CODE = 8'hA5
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [DW-1:0] rd_data_q,
    input wire host_clk_pin,
    input wire mem_clk_pin,
    input wire synth_out_pin,
    input wire synth_fb_pin,
    input wire activity_pin,
    output wire led_off,
    output wire ref_div,
    output wire fb_div,
    output reg fast_clk_q,
    output reg div_reset_n_q,
    output wire fast_synth_power_down,
    output wire fast_synth_sync_force,
    output wire [1:0] fast_synth_range,
    output wire [4:0] fast_synth_loop_divider,
    output wire [4:0] fast_synth_pump_setting,
    output wire bus_synth_power_down,
    output wire bus_synth_sync_force,
    output wire [1:0] bus_synth_range,
    output wire [4:0] bus_synth_loop_divider,
    output wire [4:0] bus_synth_pump_setting
);
    localparam NPIN = 5;
    localparam P_HOST = 0;
    localparam P_MEM = 1;
    localparam P_SOUT = 2;
    localparam P_FB = 3;
    localparam P_ACT = 4;

    ////////////////////////////////////////////////////////////////////////
    // registers

    reg [DW-1:0] ind_q;
    reg [DW-1:0] fsa_q;
    reg [DW-1:0] fsb_q;
    reg [DW-1:0] bus_q;
    reg [DW-1:0] rd_mux;
    wire hit_ind;
    wire hit_stat;
    wire hit_fsa;
    wire hit_fsb;
    wire hit_bus;
    wire hit_id;

    assign hit_ind = (addr == `LCS_OFF_IND);
    assign hit_stat = (addr == `LCS_OFF_STAT);
    assign hit_fsa = (addr == `LCS_OFF_FSA);
    assign hit_fsb = (addr == `LCS_OFF_FSB);
    assign hit_bus = (addr == `LCS_OFF_BUS);
    assign hit_id = (addr == `LCS_OFF_ID);

    // reserved bits are stored as written; software keeps them zero
    always @(posedge clk) begin
        if (!reset_n) begin
            ind_q <= `LCS_RST_IND;
            fsa_q <= `LCS_RST_FSA;
            fsb_q <= `LCS_RST_FSB;
            bus_q <= `LCS_RST_BUS;
        end else if (clk_en && wr_en) begin
            if (hit_ind) begin
                ind_q <= wr_data;
            end
            if (hit_fsa) begin
                fsa_q <= wr_data;
            end
            if (hit_fsb) begin
                fsb_q <= wr_data;
            end
            if (hit_bus) begin
                bus_q <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    reg [NPIN-1:0] pin_s1_q;
    reg [NPIN-1:0] pin_s2_q;
    // stage three only feeds the edge detect; all other logic reads stage two
    // clock pins are sampled, so a source at or above half of clk loses edges
    reg [NPIN-1:0] pin_s3_q;
    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_rise;

    assign pin_raw = {activity_pin, synth_fb_pin, synth_out_pin, mem_clk_pin, host_clk_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                if (!reset_n) begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                    pin_s3_q[gi] <= 1'b0;
                end else if (clk_en) begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_s3_q[gi] <= pin_s2_q[gi];
                end
            end
            assign pin_rise[gi] = pin_s2_q[gi] & ~pin_s3_q[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // activity indicator

    wire ind_unit_us;
    wire [TIME_W-1:0] ind_time;

    assign ind_unit_us = ind_q[`LCS_IND_UNIT];
    assign ind_time = ind_q[`LCS_IND_TIME_MSB:`LCS_IND_TIME_LSB];

    // an activity edge while already off does not stretch the off time
    lcs_off_timer #(
        .US_CYC(US_CYC),
        .MS_US(MS_US),
        .TW(TIME_W)
    ) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .start(pin_rise[P_ACT]),
        .off_time(ind_time),
        .unit_us(ind_unit_us),
        .led_off_q(led_off)
    );

    ////////////////////////////////////////////////////////////////////////
    // fast clock path

    wire src_mem;
    wire byp;
    wire sel_src;
    wire sel_rise;
    wire [DIV_W-1:0] xdiv;
    wire [DIV_W-1:0] ydiv;

    assign src_mem = fsa_q[`LCS_FSA_SRC];
    assign byp = fsa_q[`LCS_FSA_BYP];
    assign xdiv = fsa_q[`LCS_FSA_XDIV_MSB:`LCS_FSA_XDIV_LSB];
    assign ydiv = fsa_q[`LCS_FSA_YDIV_MSB:`LCS_FSA_YDIV_LSB];
    assign sel_src = src_mem ? pin_s2_q[P_MEM] : pin_s2_q[P_HOST];
    assign sel_rise = src_mem ? pin_rise[P_MEM] : pin_rise[P_HOST];

    // divider reset follows the bit one cycle later
    always @(posedge clk) begin
        if (!reset_n) begin
            div_reset_n_q <= 1'b0;
        end else if (clk_en) begin
            div_reset_n_q <= fsa_q[`LCS_FSA_NRST];
        end
    end

    lcs_edge_div #(
        .RW(DIV_W)
    ) u_ref_div (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .hold_n(div_reset_n_q),
        .ratio(xdiv),
        .src(sel_src),
        .src_rise(sel_rise),
        .div_q(ref_div)
    );

    lcs_edge_div #(
        .RW(DIV_W)
    ) u_fb_div (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .hold_n(div_reset_n_q),
        .ratio(ydiv),
        .src(pin_s2_q[P_FB]),
        .src_rise(pin_rise[P_FB]),
        .div_q(fb_div)
    );

    // bypass takes the source before the reference divider
    // a sampled copy for monitoring only, never a clock for logic
    always @(posedge clk) begin
        if (!reset_n) begin
            fast_clk_q <= 1'b0;
        end else if (clk_en) begin
            if (byp) begin
                fast_clk_q <= sel_src;
            end else begin
                fast_clk_q <= pin_s2_q[P_SOUT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synthesizer loop controls, straight from the register flops

    assign fast_synth_power_down = fsb_q[`LCS_SY_PD];
    assign fast_synth_sync_force = fsb_q[`LCS_SY_SYNC];
    assign fast_synth_range = fsb_q[`LCS_SY_RANGE_MSB:`LCS_SY_RANGE_LSB];
    assign fast_synth_loop_divider = fsb_q[`LCS_SY_LOOP_MSB:`LCS_SY_LOOP_LSB];
    assign fast_synth_pump_setting = fsb_q[`LCS_SY_PUMP_MSB:`LCS_SY_PUMP_LSB];
    assign bus_synth_power_down = bus_q[`LCS_SY_PD];
    assign bus_synth_sync_force = bus_q[`LCS_SY_SYNC];
    assign bus_synth_range = bus_q[`LCS_SY_RANGE_MSB:`LCS_SY_RANGE_LSB];
    assign bus_synth_loop_divider = bus_q[`LCS_SY_LOOP_MSB:`LCS_SY_LOOP_LSB];
    assign bus_synth_pump_setting = bus_q[`LCS_SY_PUMP_MSB:`LCS_SY_PUMP_LSB];

    ////////////////////////////////////////////////////////////////////////
    // read path

    wire [DW-1:0] stat_word;

    assign stat_word = {{(DW-5){1'b0}}, ~div_reset_n_q, fast_clk_q, fb_div, ref_div, led_off};

    // the configuration word a is write-only and reads as zero
    always @* begin
        rd_mux = {DW{1'b0}};
        if (hit_ind) begin
            rd_mux = ind_q;
        end else if (hit_stat) begin
            rd_mux = stat_word;
        end else if (hit_fsb) begin
            rd_mux = fsb_q;
        end else if (hit_bus) begin
            rd_mux = bus_q;
        end else if (hit_id) begin
            rd_mux = {REVISION_CODE, PART_CODE};
        end
    end

    // data stands for one cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (!reset_n) begin
            rd_data_q <= {DW{1'b0}};
        end else if (clk_en) begin
            rd_data_q <= rd_en ? rd_mux : {DW{1'b0}};
        end
    end
endmodule // lcs_config_bank
`default_nettype wire

// File: core/lcs_consts.vh
// constants for the indicator and clock synthesizer configuration bank
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH

// register offsets, as used on the address port
`define LCS_OFF_IND 9'h10C
`define LCS_OFF_STAT 9'h10E
`define LCS_OFF_FSA 9'h16C
`define LCS_OFF_FSB 9'h172
`define LCS_OFF_BUS 9'h174
`define LCS_OFF_ID 9'h17E

// reset values
`define LCS_RST_IND 16'h007F
`define LCS_RST_FSA 16'h0642
`define LCS_RST_FSB 16'h09FC
`define LCS_RST_BUS 16'h07FE

// indicator_timing fields
`define LCS_IND_TIME_MSB 8
`define LCS_IND_TIME_LSB 0
`define LCS_IND_UNIT 9

// fast_synth_config_a fields
`define LCS_FSA_XDIV_MSB 3
`define LCS_FSA_XDIV_LSB 1
`define LCS_FSA_YDIV_MSB 6
`define LCS_FSA_YDIV_LSB 4
`define LCS_FSA_BYP 7
`define LCS_FSA_SRC 8
`define LCS_FSA_NRST 9

// synthesizer loop fields, shared by both loop registers
`define LCS_SY_RANGE_MSB 1
`define LCS_SY_RANGE_LSB 0
`define LCS_SY_PD 2
`define LCS_SY_LOOP_MSB 7
`define LCS_SY_LOOP_LSB 3
`define LCS_SY_SYNC 8
`define LCS_SY_PUMP_MSB 13
`define LCS_SY_PUMP_LSB 9

// status fields
`define LCS_ST_LED_OFF 0
`define LCS_ST_REF_DIV 1
`define LCS_ST_FB_DIV 2
`define LCS_ST_FAST_CLK 3
`define LCS_ST_DIV_HELD 4

// timing: clock period, one microsecond, microseconds per millisecond
`define LCS_CLK_PS 5000
`define LCS_US_PS 1000000
`define LCS_US_CYC ((`LCS_US_PS) / (`LCS_CLK_PS))
`define LCS_MS_US 1000

`endif

// File: core/lcs_edge_div.v
// integer divider driven by the rising edges of a sampled clock
`timescale 1ns/1ps
`default_nettype none
module lcs_edge_div #(
    parameter RW = 3
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire hold_n,
    input wire [RW-1:0] ratio,
    input wire src,
    input wire src_rise,
    output reg div_q
);
    reg [RW-1:0] cnt_q;
    reg [RW-1:0] nxt;

    always @* begin
        nxt = (cnt_q == ratio) ? {RW{1'b0}} : cnt_q + {{(RW-1){1'b0}}, 1'b1};
    end

    // divides by ratio + 1; ratio 0 passes the source through
    always @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= {RW{1'b0}};
            div_q <= 1'b0;
        end else if (clk_en) begin
            if (!hold_n) begin
                cnt_q <= {RW{1'b0}};
                div_q <= 1'b0;
            end else if (ratio == {RW{1'b0}}) begin
                cnt_q <= {RW{1'b0}};
                div_q <= src;
            end else if (src_rise) begin
                cnt_q <= nxt;
                div_q <= (nxt <= (ratio >> 1));
            end
        end
    end
endmodule // lcs_edge_div
`default_nettype wire

// File: core/lcs_off_timer.v
// indicator off-time timer with microsecond and millisecond time base
`timescale 1ns/1ps
`default_nettype none
module lcs_off_timer #(
    parameter US_CYC = 200,
    parameter MS_US = 1000,
    parameter TW = 9
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire start,
    input wire [TW-1:0] off_time,
    input wire unit_us,
    output reg led_off_q
);
    // prescalers are 16 bits: more than 65536 cycles per microsecond or microseconds per millisecond do not fit
    localparam [31:0] US_LAST_W = US_CYC - 1;
    localparam [31:0] MS_LAST_W = MS_US - 1;
    localparam [15:0] US_LAST = US_LAST_W[15:0];
    localparam [15:0] MS_LAST = MS_LAST_W[15:0];

    reg [15:0] pre_q;
    reg [15:0] ms_q;
    reg [TW-1:0] cnt_q;
    reg unit_q;
    wire us_tick;
    wire ms_tick;
    wire unit_tick;

    assign us_tick = (pre_q == US_LAST);
    assign ms_tick = us_tick && (ms_q == MS_LAST);
    assign unit_tick = unit_q ? us_tick : ms_tick;

    always @(posedge clk) begin
        if (!reset_n) begin
            pre_q <= 16'h0000;
            ms_q <= 16'h0000;
            cnt_q <= {TW{1'b0}};
            unit_q <= 1'b0;
            led_off_q <= 1'b0;
        end else if (clk_en) begin
            // prescalers restart so the first unit is a full one
            if (start && !led_off_q) begin
                pre_q <= 16'h0000;
                ms_q <= 16'h0000;
                cnt_q <= off_time;
                unit_q <= unit_us;
                led_off_q <= (off_time != {TW{1'b0}});
            end else if (led_off_q) begin
                pre_q <= us_tick ? 16'h0000 : pre_q + 16'h0001;
                if (us_tick) begin
                    ms_q <= ms_tick ? 16'h0000 : ms_q + 16'h0001;
                end
                if (unit_tick) begin
                    cnt_q <= cnt_q - {{(TW-1){1'b0}}, 1'b1};
                    if (cnt_q == {{(TW-1){1'b0}}, 1'b1}) begin
                        led_off_q <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // lcs_off_timer
`default_nettype wire

// File: testbench/lcs_checker_assertions.sv
// port-level assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module lcs_checker #(
    // arbitrary identification values
    parameter [7:0] PART_CODE = 8'h5A,
    parameter [7:0] REVISION_CODE = 8'hA5
) (
    input wire clk,
    input wire reset_n,
    input wire [8:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rd_data_q,
    input wire activity_pin,
    input wire led_off,
    input wire ref_div,
    input wire fb_div,
    input wire div_reset_n_q,
    input wire fast_synth_power_down,
    input wire fast_synth_sync_force,
    input wire [1:0] fast_synth_range,
    input wire [4:0] fast_synth_loop_divider,
    input wire [4:0] fast_synth_pump_setting
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////////
    a_id_read_const: assert property (
        $past(rd_en && addr == 9'h17E) |-> rd_data_q == {REVISION_CODE, PART_CODE})
        else $error("identification word wrong");
    a_wo_read_zero: assert property (
        $past(rd_en && addr == 9'h16C) |-> rd_data_q == 16'h0000)
        else $error("write-only register read not zero");
    a_led_after_activity: assert property (
        $rose(led_off) |-> $past(activity_pin, 3))
        else $error("indicator went off without activity");
    a_led_min_unit: assert property (
        $rose(led_off) |-> led_off [*4])
        else $error("indicator off shorter than one unit");
    a_div_held_low: assert property (
        !div_reset_n_q && $past(!div_reset_n_q) |-> !ref_div && !fb_div)
        else $error("divider moved while held");
    a_div_reset_copy: assert property (
        wr_en && addr == 9'h16C |-> ##2 div_reset_n_q == $past(wr_data[9], 2))
        else $error("divider reset does not follow write");
    a_power_sync_write: assert property (
        $past(wr_en && addr == 9'h172) |->
        {fast_synth_power_down, fast_synth_sync_force} == {$past(wr_data[2]), $past(wr_data[8])})
        else $error("power-down or sync output wrong");
    a_loop_fields_write: assert property (
        $past(wr_en && addr == 9'h172) |->
        {fast_synth_pump_setting, fast_synth_loop_divider, fast_synth_range}
        == {$past(wr_data[13:9]), $past(wr_data[7:3]), $past(wr_data[1:0])})
        else $error("loop fields wrong");
    c_led_pulse: cover property ($rose(led_off));
    c_div_hold: cover property ($fell(div_reset_n_q));
    c_id_read: cover property (rd_en && addr == 9'h17E);
endmodule // lcs_checker
`default_nettype wire

// File: testbench/lcs_config_bank_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module lcs_config_bank_tb;
    localparam int UC = 4;
    localparam int MU = 3;
    logic clk, reset_n, wr_en, rd_en, host, mem, sout, sfb, act, ce;
    logic [8:0] addr;
    logic [15:0] wr_data;
    wire [15:0] rd_data_q;
    wire led_off, ref_div, fb_div, fast_clk_q, div_reset_n_q, fpd, fsy, bpd, bsy;
    wire [1:0] frg, brg;
    wire [4:0] flp, fpm, blp, bpm;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [15:0] fv [2] = '{16'h11FC, 16'h10F8};
    logic [15:0] bv [2] = '{16'h07FA, 16'h06FE};

    lcs_config_bank #(.US_CYC(UC), .MS_US(MU)) u_dut (
        .clk(clk), .reset_n(reset_n), .clk_en(ce), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .host_clk_pin(host),
        .mem_clk_pin(mem), .synth_out_pin(sout), .synth_fb_pin(sfb), .activity_pin(act),
        .led_off(led_off), .ref_div(ref_div), .fb_div(fb_div), .fast_clk_q(fast_clk_q),
        .div_reset_n_q(div_reset_n_q), .fast_synth_power_down(fpd),
        .fast_synth_sync_force(fsy), .fast_synth_range(frg), .fast_synth_loop_divider(flp),
        .fast_synth_pump_setting(fpm), .bus_synth_power_down(bpd), .bus_synth_sync_force(bsy),
        .bus_synth_range(brg), .bus_synth_loop_divider(blp), .bus_synth_pump_setting(bpm));
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rdc(input logic [8:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk("read data", rd_data_q, exp);
    endtask
    // 16 source periods; edge counts allow one period of sync slack
    task automatic div_run(input logic [15:0] cfg, input int ex);
        int nr, nf;
        logic pr, pf;
        wr(9'h16C, cfg);
        repeat (3) @(posedge clk);
        @(negedge clk);
        nr = 0;
        nf = 0;
        for (int i = 0; i < 96; i++) begin
            pr = ref_div;
            pf = fb_div;
            @(posedge clk);
            if (i % 3 == 0) begin
                host <= ~host;
                sfb <= ~sfb;
                sout <= ~sout;
            end
            @(negedge clk);
            nr += int'(ref_div === 1'b1 && pr === 1'b0);
            nf += int'(fb_div === 1'b1 && pf === 1'b0);
        end
        chk("ref rises", 16'(ex == 0 ? nr == 0 : nr >= ex - 1 && nr <= ex + 1), 16'h1);
        chk("fb rises", 16'(ex == 0 ? nf == 0 : nf >= ex - 1 && nf <= ex + 1), 16'h1);
    endtask
    // a second activity edge lands while off: the timer must not retrigger
    task automatic led_run(input logic [15:0] cfg, input int ex);
        int n;
        wr(9'h10C, cfg);
        n = 0;
        @(posedge clk);
        act <= 1'b1;
        for (int i = 0; i < 120; i++) begin
            @(posedge clk);
            if (i == 8 || i == 18) act <= 1'b0;
            if (i == 10) act <= 1'b1;
            @(negedge clk);
            n += int'(led_off === 1'b1);
        end
        chk("off time", 16'(n >= ex && n <= ex + 1), 16'h1);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        {reset_n, wr_en, rd_en, host, mem, sout, sfb, act} = 8'h00;
        addr = 9'h000;
        ce = 1'b1;
        wr_data = 16'h0000;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rdc(9'h10C, 16'h007F);
        rdc(9'h172, 16'h09FC);
        rdc(9'h174, 16'h07FE);
        rdc(9'h16C, 16'h0000);
        rdc(9'h17E, 16'hA55A);
        rdc(9'h100, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            wr(9'h172, fv[i]);
            wr(9'h174, bv[i]);
            rdc(9'h172, fv[i]);
            rdc(9'h174, bv[i]);
            chk("fast fields", {2'b00, fpm, fsy, flp, fpd, frg}, fv[i] & 16'h3FFF);
            chk("bus fields", {2'b00, bpm, bsy, blp, bpd, brg}, bv[i] & 16'h3FFF);
        end
        wr(9'h10C, 16'h0205);
        rdc(9'h10C, 16'h0205);
        // a write with the clock enable low must leave the register alone
        @(posedge clk);
        ce <= 1'b0;
        wr(9'h10C, 16'h0001);
        @(posedge clk);
        ce <= 1'b1;
        rdc(9'h10C, 16'h0205);
        wr(9'h17E, 16'hFFFF);
        rdc(9'h17E, 16'hA55A);
        for (int s = 0; s < 2; s++) begin
            wr(9'h16C, 16'h0680 | 16'(s << 8));
            for (int i = 0; i < 4; i++) begin
                @(posedge clk);
                host <= i[0];
                mem <= ~i[0];
                repeat (6) @(posedge clk);
                @(negedge clk);
                chk("bypass", 16'(fast_clk_q), 16'(i[0] ^ s[0]));
            end
        end
        // bypass off: the synthesizer output, not the source, reaches the fast clock
        wr(9'h16C, 16'h0600);
        @(posedge clk);
        host <= 1'b0;
        sout <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("synth out", 16'(fast_clk_q), 16'h0001);
        // ratio r sits in both divide fields: r*2 + r*16
        for (int r = 0; r < 4; r += 1 + r) div_run(16'h0600 | 16'(r * 18), 16 / (r + 1));
        div_run(16'h0412, 0);
        chk("div reset", 16'(div_reset_n_q), 16'h0);
        led_run(16'h0203, 3 * UC);
        led_run(16'h0003, 3 * MU * UC);
        led_run(16'h0000, 0);
        rdc(9'h10E, 16'h0010 | (16'(sout) << 3));
        give_verdict();
    end
endmodule // lcs_config_bank_tb

bind lcs_config_bank lcs_checker #(.PART_CODE(PART_CODE), .REVISION_CODE(REVISION_CODE)) u_chk (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_q(rd_data_q), .activity_pin(activity_pin), .led_off(led_off),
    .ref_div(ref_div), .fb_div(fb_div), .div_reset_n_q(div_reset_n_q),
    .fast_synth_power_down(fast_synth_power_down), .fast_synth_sync_force(fast_synth_sync_force),
    .fast_synth_range(fast_synth_range), .fast_synth_loop_divider(fast_synth_loop_divider),
    .fast_synth_pump_setting(fast_synth_pump_setting));
`default_nettype wire
